/* File: design/hcp_cursor_ctrl.sv */
// Hardware cursor position and control registers with indexed port access.
// Assumes a byte I/O bus presenting one-cycle read and write strobes.
`include "hcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module hcp_cursor_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // I/O bus
  input wire hcp_pkg::hcp_req_type req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Cursor 1 configuration
  output logic [21:0] c1_base_o,
  output logic [3:0] c1_pattern_o,
  output hcp_pkg::hcp_pos_type c1_xpos_o,
  output hcp_pkg::hcp_pos_type c1_ypos_o,
  output logic [21:0] c1_pattern_addr_o,
  output logic [8:0] c1_pattern_count_o,
  // Cursor 2 control
  output hcp_pkg::hcp_ctl_type c2_ctl_o,
  output logic c2_blink_o,
  output logic c2_vstretch_o,
  output logic c2_hstretch_o,
  output logic c2_origin_active_o,
  output logic c2_vext_o,
  output hcp_pkg::hcp_mode_type c2_mode_o
);

  hcp_pkg::hcp_state_type state_reg;
  hcp_pkg::hcp_state_type state_next;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic [7:0] sel_byte;

  // ==========================================================
  // Port decode
  assign idx_wr = req_i.wr && (req_i.addr == `HCP_PORT_INDEX);
  assign dat_wr = req_i.wr && (req_i.addr == `HCP_PORT_DATA);
  assign dat_rd = req_i.rd && (req_i.addr == `HCP_PORT_DATA);

  // ==========================================================
  // Read mux on current index
  always_comb begin
    case (state_reg.index)
      `HCP_IDX_C1_BASE_LO: sel_byte = state_reg.base_lo;
      `HCP_IDX_C1_BASE_HI: sel_byte = {2'b00, state_reg.base_hi};
      `HCP_IDX_C1_XPOS_LO: sel_byte = state_reg.xpos.mag[7:0];
      `HCP_IDX_C1_XPOS_HI:
        sel_byte = {state_reg.xpos.sign, 4'h0, state_reg.xpos.mag[10:8]};
      `HCP_IDX_C1_YPOS_LO: sel_byte = state_reg.ypos.mag[7:0];
      `HCP_IDX_C1_YPOS_HI:
        sel_byte = {state_reg.ypos.sign, 4'h0, state_reg.ypos.mag[10:8]};
      `HCP_IDX_C2_CONTROL: sel_byte = state_reg.ctl;
      default: sel_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    if (idx_wr) begin
      state_next.index = req_i.wdata;
    end
    if (dat_wr) begin
      case (state_reg.index)
        `HCP_IDX_C1_BASE_LO: state_next.base_lo = req_i.wdata;
        `HCP_IDX_C1_BASE_HI: state_next.base_hi = req_i.wdata[5:0];
        `HCP_IDX_C1_XPOS_LO: state_next.xpos.mag[7:0] = req_i.wdata;
        `HCP_IDX_C1_XPOS_HI: begin
          state_next.xpos.sign = req_i.wdata[7];
          state_next.xpos.mag[10:8] = req_i.wdata[2:0];
        end
        `HCP_IDX_C1_YPOS_LO: state_next.ypos.mag[7:0] = req_i.wdata;
        `HCP_IDX_C1_YPOS_HI: begin
          state_next.ypos.sign = req_i.wdata[7];
          state_next.ypos.mag[10:8] = req_i.wdata[2:0];
        end
        `HCP_IDX_C2_CONTROL:
          state_next.ctl = hcp_pkg::hcp_ctl_type'(req_i.wdata);
        default: state_next.index = state_reg.index;
      endcase
    end
    if (dat_rd) begin
      state_next.rdata = sel_byte;
      state_next.rvalid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata_o = state_reg.rdata;
  assign rvalid_o = state_reg.rvalid;
  assign c1_base_o = {state_reg.base_hi, state_reg.base_lo[7:4], 12'h000};
  assign c1_pattern_o = state_reg.base_lo[3:0];
  assign c1_xpos_o = state_reg.xpos;
  assign c1_ypos_o = state_reg.ypos;
  assign c2_ctl_o = state_reg.ctl;
  assign c2_blink_o = state_reg.ctl.blink;
  assign c2_vstretch_o = state_reg.ctl.vstretch;
  assign c2_hstretch_o = state_reg.ctl.hstretch;
  assign c2_origin_active_o = state_reg.ctl.origin;
  assign c2_vext_o = state_reg.ctl.vext;
  assign c2_mode_o = state_reg.ctl.mode;

  // ==========================================================
  // Cursor 1 pattern address; mode comes from cursor 2 control here
  hcp_pattern_addr u_pat (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .base_i(c1_base_o),
    .select_i(c1_pattern_o),
    .mode_i(state_reg.ctl.mode),
    .addr_o(c1_pattern_addr_o),
    .count_o(c1_pattern_count_o)
  );

  // ==========================================================
  // Checks: port access
  chk_index_write: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    idx_wr |=> state_reg.index == $past(req_i.wdata))
    else $error("index not captured");
  chk_index_hold: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !idx_wr |=> $stable(state_reg.index))
    else $error("index changed without an index write");
  chk_read_latency: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_rd |=> rvalid_o && rdata_o == $past(sel_byte))
    else $error("read answer wrong");
  chk_rvalid_pulse: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !dat_rd |=> !rvalid_o)
    else $error("read answer without a read");
  chk_rdata_hold: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !dat_rd |=> $stable(rdata_o))
    else $error("read byte changed without a read");
  chk_unknown_read: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_rd && (state_reg.index < `HCP_IDX_C1_BASE_LO
    || state_reg.index > `HCP_IDX_C2_CONTROL) |=> rdata_o == 8'h00)
    else $error("unknown index read not zero");
  chk_unknown_write: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && (state_reg.index < `HCP_IDX_C1_BASE_LO
    || state_reg.index > `HCP_IDX_C2_CONTROL)
    |=> $stable({c1_base_o, c1_xpos_o, c1_ypos_o, c2_ctl_o}))
    else $error("unknown index write changed a register");
  chk_other_port: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (req_i.wr || req_i.rd) && req_i.addr != `HCP_PORT_INDEX
    && req_i.addr != `HCP_PORT_DATA
    |=> $stable(state_reg.index) && !rvalid_o)
    else $error("foreign port access taken");

  // ==========================================================
  // Checks: base and pattern
  chk_base_low: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C1_BASE_LO
    |=> c1_base_o[15:12] == $past(req_i.wdata[7:4]))
    else $error("base low not applied");
  chk_base_high: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C1_BASE_HI
    |=> c1_base_o[21:16] == $past(req_i.wdata[5:0]))
    else $error("base high not applied");
  chk_base_rsvd: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_rd && state_reg.index == `HCP_IDX_C1_BASE_HI
    |=> rdata_o[7:6] == 2'b00)
    else $error("reserved bits nonzero");
  chk_pattern_sel: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C1_BASE_LO
    |=> c1_pattern_o == $past(req_i.wdata[3:0]))
    else $error("pattern select wrong");
  chk_base_hold: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !dat_wr |=> $stable(c1_base_o) && $stable(c1_pattern_o))
    else $error("base changed without a write");

  // ==========================================================
  // Checks: positions
  chk_xpos_low: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C1_XPOS_LO
    |=> c1_xpos_o.mag[7:0] == $past(req_i.wdata))
    else $error("x low wrong");
  chk_xpos_sign: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C1_XPOS_HI
    |=> c1_xpos_o.sign == $past(req_i.wdata[7])
    && c1_xpos_o.mag[10:8] == $past(req_i.wdata[2:0]))
    else $error("x high wrong");
  chk_xpos_rsvd: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_rd && state_reg.index == `HCP_IDX_C1_XPOS_HI
    |=> rdata_o[6:3] == 4'h0)
    else $error("x high reserved bits nonzero");
  chk_ypos_low: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C1_YPOS_LO
    |=> c1_ypos_o.mag[7:0] == $past(req_i.wdata))
    else $error("y low wrong");
  chk_ypos_high: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C1_YPOS_HI
    |=> c1_ypos_o.sign == $past(req_i.wdata[7])
    && c1_ypos_o.mag[10:8] == $past(req_i.wdata[2:0]))
    else $error("y high wrong");
  chk_ypos_rsvd: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_rd && state_reg.index == `HCP_IDX_C1_YPOS_HI
    |=> rdata_o[6:3] == 4'h0)
    else $error("y high reserved bits nonzero");
  chk_pos_hold: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !dat_wr |=> $stable(c1_xpos_o) && $stable(c1_ypos_o))
    else $error("position changed without a write");

  // ==========================================================
  // Checks: cursor 2 control
  chk_ctl_reset: assert property (
    @(posedge clk_sys_i)
    $rose(resetn_i) |-> c2_ctl_o == 8'h00 && !c2_blink_o && !c2_vext_o)
    else $error("control not cleared");
  chk_ctl_fields: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C2_CONTROL
    |=> c2_vstretch_o == $past(req_i.wdata[`HCP_CTL_VSTRETCH])
    && c2_hstretch_o == $past(req_i.wdata[`HCP_CTL_HSTRETCH])
    && c2_origin_active_o == $past(req_i.wdata[`HCP_CTL_ORIGIN])
    && c2_mode_o == $past(req_i.wdata[2:0]))
    else $error("control fields wrong");
  chk_ctl_blink_vext: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_wr && state_reg.index == `HCP_IDX_C2_CONTROL
    |=> c2_blink_o == $past(req_i.wdata[`HCP_CTL_BLINK])
    && c2_vext_o == $past(req_i.wdata[`HCP_CTL_VEXT]))
    else $error("blink or extension bit wrong");
  chk_ctl_readback: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    dat_rd && state_reg.index == `HCP_IDX_C2_CONTROL
    |=> rdata_o == $past(c2_ctl_o))
    else $error("control read back wrong");
  chk_ctl_hold: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !dat_wr |=> $stable(c2_ctl_o))
    else $error("control changed without a write");

  // ==========================================================
  // Checks: pattern address and count, one cycle behind the mode
  chk_pat_addr: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    c2_mode_o == hcp_pkg::HCP_MODE_32_ANDXOR
    |=> c1_pattern_addr_o
    == $past(c1_base_o) + {10'h000, $past(c1_pattern_o), 8'h00})
    else $error("pattern address wrong");
  chk_pat_addr_128: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (c2_mode_o == hcp_pkg::HCP_MODE_128_2COLOR
    || c2_mode_o == hcp_pkg::HCP_MODE_128_1COLOR)
    |=> c1_pattern_addr_o
    == $past(c1_base_o) + {7'h00, $past(c1_pattern_o), 11'h000})
    else $error("large pattern address wrong");
  chk_pat_addr_64: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (c2_mode_o == hcp_pkg::HCP_MODE_64_3COLOR
    || c2_mode_o == hcp_pkg::HCP_MODE_64_ANDXOR
    || c2_mode_o == hcp_pkg::HCP_MODE_64_4COLOR)
    |=> c1_pattern_addr_o
    == $past(c1_base_o) + {8'h00, $past(c1_pattern_o), 10'h000})
    else $error("medium pattern address wrong");
  chk_count_32: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    c2_mode_o == hcp_pkg::HCP_MODE_32_ANDXOR
    |=> c1_pattern_count_o == 9'h010)
    else $error("count wrong for small cursor");
  chk_count_128: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (c2_mode_o == hcp_pkg::HCP_MODE_128_2COLOR
    || c2_mode_o == hcp_pkg::HCP_MODE_128_1COLOR)
    |=> c1_pattern_count_o == 9'h002)
    else $error("count wrong for large cursor");
  chk_count_64: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (c2_mode_o == hcp_pkg::HCP_MODE_64_3COLOR
    || c2_mode_o == hcp_pkg::HCP_MODE_64_ANDXOR
    || c2_mode_o == hcp_pkg::HCP_MODE_64_4COLOR)
    |=> c1_pattern_count_o == 9'h004)
    else $error("count wrong for medium cursor");
  chk_count_off: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (c2_mode_o == hcp_pkg::HCP_MODE_OFF
    || c2_mode_o == hcp_pkg::HCP_MODE_RSVD)
    |=> c1_pattern_count_o == 9'h000)
    else $error("count not zero with cursor off");

endmodule : hcp_cursor_ctrl

`default_nettype wire

/* File: design/hcp_cfg.svh */
// Constants for the hardware cursor position and control block.
// Assumes byte-wide indexed register access through an index/data port pair.
`ifndef HCP_CFG_SVH
`define HCP_CFG_SVH

// ============================================================
// Port addresses
`define HCP_PORT_INDEX 16'h03D6
`define HCP_PORT_DATA 16'h03D7

// ============================================================
// Register indices
`define HCP_IDX_C1_BASE_LO 8'hA2
`define HCP_IDX_C1_BASE_HI 8'hA3
`define HCP_IDX_C1_XPOS_LO 8'hA4
`define HCP_IDX_C1_XPOS_HI 8'hA5
`define HCP_IDX_C1_YPOS_LO 8'hA6
`define HCP_IDX_C1_YPOS_HI 8'hA7
`define HCP_IDX_C2_CONTROL 8'hA8

// ============================================================
// Field positions and masks
`define HCP_BASE_HI_MASK 8'h3F
`define HCP_POS_HI_MASK 8'h87
`define HCP_CTL_BLINK 7
`define HCP_CTL_VSTRETCH 6
`define HCP_CTL_HSTRETCH 5
`define HCP_CTL_ORIGIN 4
`define HCP_CTL_VEXT 3

// ============================================================
// Reset values
`define HCP_RESET_BYTE 8'h00
`define HCP_RESET_INDEX 8'h00

// ============================================================
// Cursor storage area, bytes
`define HCP_STORE_BYTES 22'h00_1000

`endif

/* File: design/hcp_pkg.sv */
// Types for the hardware cursor position and control block.
// Assumes hcp_cfg.svh supplies the numeric constants.
package hcp_pkg;

  // Cursor 2 display mode
  typedef enum logic [2:0] {
    HCP_MODE_OFF,
    HCP_MODE_32_ANDXOR,
    HCP_MODE_128_2COLOR,
    HCP_MODE_128_1COLOR,
    HCP_MODE_64_3COLOR,
    HCP_MODE_64_ANDXOR,
    HCP_MODE_64_4COLOR,
    HCP_MODE_RSVD
  } hcp_mode_type;

  // Cursor 2 control fields
  typedef struct packed {
    logic blink;
    logic vstretch;
    logic hstretch;
    logic origin;
    logic vext;
    hcp_mode_type mode;
  } hcp_ctl_type;

  // Sign-magnitude position
  typedef struct packed {
    logic sign;
    logic [10:0] mag;
  } hcp_pos_type;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } hcp_req_type;

  // All block state
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] base_lo;
    logic [5:0] base_hi;
    hcp_pos_type xpos;
    hcp_pos_type ypos;
    hcp_ctl_type ctl;
    logic [7:0] rdata;
    logic rvalid;
  } hcp_state_type;

  // Pattern address helper state
  typedef struct packed {
    logic [21:0] addr;
    logic [8:0] count;
  } hcp_pat_state_type;

endpackage : hcp_pkg

/* File: design/hcp_pattern_addr.sv */
// Pattern start address from base, pattern select and mode.
// Assumes hcp_pkg and hcp_cfg.svh are compiled first.
`include "hcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module hcp_pattern_addr (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Configuration
  input wire logic [21:0] base_i,
  input wire logic [3:0] select_i,
  input wire hcp_pkg::hcp_mode_type mode_i,
  // Result
  output logic [21:0] addr_o,
  output logic [8:0] count_o
);

  hcp_pkg::hcp_pat_state_type state_reg;
  hcp_pkg::hcp_pat_state_type state_next;
  logic [21:0] size;
  logic [21:0] offset;

  // ==========================================================
  // Pattern size per mode
  always_comb begin
    case (mode_i)
      hcp_pkg::HCP_MODE_32_ANDXOR: size = 22'h00_0100;
      hcp_pkg::HCP_MODE_128_2COLOR: size = 22'h00_0800;
      hcp_pkg::HCP_MODE_128_1COLOR: size = 22'h00_0800;
      hcp_pkg::HCP_MODE_64_3COLOR: size = 22'h00_0400;
      hcp_pkg::HCP_MODE_64_ANDXOR: size = 22'h00_0400;
      hcp_pkg::HCP_MODE_64_4COLOR: size = 22'h00_0400;
      default: size = 22'h00_0000;
    endcase
  end

  // ==========================================================
  // Address and usable pattern count
  always_comb begin
    offset = size * {18'h0_0000, select_i};
    state_next = state_reg;
    state_next.addr = base_i + offset;
    if (size == 22'h00_0000) begin
      state_next.count = 9'h000;
    end else begin
      state_next.count = 9'((`HCP_STORE_BYTES / size));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign addr_o = state_reg.addr;
  assign count_o = state_reg.count;

  chk_count_bound: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    count_o <= 9'h010)
    else $error("pattern count too large");

endmodule : hcp_pattern_addr

`default_nettype wire

/* File: bench/test_hw_cursor_position_control.sv */
// Self-checking bench for the cursor position and control registers.
// Assumes hcp_pkg, hcp_cfg.svh and hcp_cursor_ctrl are compiled first.
`include "hcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_hw_cursor_position_control;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  hcp_pkg::hcp_req_type req_i = '0;
  logic [7:0] rdata_o;
  logic rvalid_o;
  logic [21:0] c1_base_o;
  logic [3:0] c1_pattern_o;
  hcp_pkg::hcp_pos_type c1_xpos_o;
  hcp_pkg::hcp_pos_type c1_ypos_o;
  logic [21:0] c1_pattern_addr_o;
  logic [8:0] c1_pattern_count_o;
  hcp_pkg::hcp_ctl_type c2_ctl_o;
  logic c2_blink_o;
  logic c2_vstretch_o;
  logic c2_hstretch_o;
  logic c2_origin_active_o;
  logic c2_vext_o;
  hcp_pkg::hcp_mode_type c2_mode_o;
  int fail_count = 0;
  int n_checks = 0;
  int m;
  logic [7:0] ctl;
  logic [21:0] size;
  logic [7:0] flags;

  always #50 clk_sys_i = ~clk_sys_i;

  hcp_cursor_ctrl i_dut (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .rvalid_o(rvalid_o),
    .c1_base_o(c1_base_o),
    .c1_pattern_o(c1_pattern_o),
    .c1_xpos_o(c1_xpos_o),
    .c1_ypos_o(c1_ypos_o),
    .c1_pattern_addr_o(c1_pattern_addr_o),
    .c1_pattern_count_o(c1_pattern_count_o),
    .c2_ctl_o(c2_ctl_o),
    .c2_blink_o(c2_blink_o),
    .c2_vstretch_o(c2_vstretch_o),
    .c2_hstretch_o(c2_hstretch_o),
    .c2_origin_active_o(c2_origin_active_o),
    .c2_vext_o(c2_vext_o),
    .c2_mode_o(c2_mode_o)
  );

  // ============================================================
  // Bus access
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic bus_op(input logic wr, input logic [15:0] a,
                        input logic [7:0] d);
    @(negedge clk_sys_i);
    req_i <= '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(negedge clk_sys_i);
    req_i <= '0;
  endtask : bus_op

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    bus_op(1'b1, `HCP_PORT_INDEX, idx);
    bus_op(1'b1, `HCP_PORT_DATA, d);
  endtask : wr_reg

  // Read the data port; answer awaited under a bounded count
  task automatic rd_data(input logic [7:0] exp);
    int k;
    k = 0;
    bus_op(1'b0, `HCP_PORT_DATA, 8'h00);
    while (rvalid_o !== 1'b1 && k < 4) begin
      @(negedge clk_sys_i);
      k++;
    end
    if (k == 4) begin
      fail_count++;
      $display("CHECK FAILED at %0t: no read answer", $time);
      report_and_stop();
    end
    `CHK(rdata_o, exp)
  endtask : rd_data

  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    bus_op(1'b1, `HCP_PORT_INDEX, idx);
    rd_data(exp);
  endtask : rd_reg

  // ============================================================
  // Tests
  initial begin
    repeat (12) @(negedge clk_sys_i);
    resetn_i <= 1'b1;
    `CHK({c1_base_o, c1_xpos_o, c1_ypos_o, c2_ctl_o}, 54'h0)
    for (m = 8'hA2; m <= 8'hA8; m++) begin
      rd_reg(8'(m), 8'h00);
    end
    $display("test reset_values done");

    wr_reg(`HCP_IDX_C1_BASE_LO, 8'hB5);
    wr_reg(`HCP_IDX_C1_BASE_HI, 8'hFF);
    rd_reg(`HCP_IDX_C1_BASE_HI, 8'h3F);
    rd_reg(`HCP_IDX_C1_BASE_LO, 8'hB5);
    `CHK(c1_base_o, 22'h3F_B000)
    `CHK(c1_pattern_o, 4'h5)
    $display("test base_pattern done");

    wr_reg(`HCP_IDX_C1_XPOS_LO, 8'h55);
    wr_reg(`HCP_IDX_C1_XPOS_HI, 8'hFF);
    wr_reg(`HCP_IDX_C1_YPOS_LO, 8'hAA);
    wr_reg(`HCP_IDX_C1_YPOS_HI, 8'h7A);
    rd_reg(`HCP_IDX_C1_XPOS_HI, 8'h87);
    rd_reg(`HCP_IDX_C1_YPOS_HI, 8'h02);
    rd_reg(`HCP_IDX_C1_YPOS_LO, 8'hAA);
    `CHK(c1_xpos_o, 12'hF55)
    `CHK(c1_ypos_o, 12'h2AA)
    $display("test positions done");

    // Every mode, with the flag bits varied from one mode to the next
    for (m = 0; m < 8; m++) begin
      ctl = {m[2:0] ^ 3'h5, ~m[0], m[1], m[2:0]};
      wr_reg(`HCP_IDX_C2_CONTROL, ctl);
      rd_reg(`HCP_IDX_C2_CONTROL, ctl);
      case (m)
        1: size = 22'h00_0100;
        2, 3: size = 22'h00_0800;
        4, 5, 6: size = 22'h00_0400;
        default: size = 22'h00_0000;
      endcase
      flags = {c2_blink_o, c2_vstretch_o, c2_hstretch_o,
               c2_origin_active_o, c2_vext_o, c2_mode_o};
      `CHK(flags, ctl)
      `CHK(c2_ctl_o, ctl)
      `CHK(c1_pattern_count_o, (size == 0) ? 9'h000 : 9'(4096 / size))
      if (size != 0) begin
        `CHK(c1_pattern_addr_o, 22'h3F_B000 + 22'(size * 5))
      end
    end
    $display("test control_modes done");

    // Unknown index A9 reads zero; index held across data reads and a foreign port write
    wr_reg(8'hA9, 8'h0F);
    rd_reg(8'hA9, 8'h00);
    bus_op(1'b1, `HCP_PORT_INDEX, `HCP_IDX_C1_XPOS_LO);
    rd_data(8'h55);
    bus_op(1'b1, 16'h03D5, `HCP_IDX_C1_BASE_LO);
    rd_data(8'h55);
    $display("test index_port done");

    @(negedge clk_sys_i);
    resetn_i <= 1'b0;
    @(negedge clk_sys_i);
    resetn_i <= 1'b1;
    `CHK({c1_base_o, c1_xpos_o, c1_ypos_o, c2_ctl_o}, 54'h0)
    rd_reg(`HCP_IDX_C2_CONTROL, 8'h00);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule : test_hw_cursor_position_control

`default_nettype wire
